// File: design/dcpa_arbiter.sv
/*
 Four-channel DMA priority arbiter with request pending, address mode
 decode and a unit-transfer bus sequencer. Assumes a bus-cycle engine
 that grants the bus and acknowledges each bus cycle on ref_clk.
*/
`timescale 1ns/100ps
module dcpa_arbiter (
  input  logic                                     ref_clk,
  input  logic                                     rstn,
  input  logic                                     prioModeHi,
  input  logic                                     prioModeLo,
  input  dcpa_pkg::dcpa_cfg_type [dcpa_pkg::NCH-1:0] chCfg,
  input  logic [dcpa_pkg::NCH-1:0]                 chanEn,
  input  logic [dcpa_pkg::NCH-1:0]                 periphReq,
  input  logic                                     extReqPinChA_n,
  input  logic                                     extReqPinChB_n,
  input  logic                                     busGranted,
  input  logic                                     cycleAck,
  output logic [dcpa_pkg::NCH-1:0]                 grant,
  output logic                                     busReq,
  output logic                                     readCycle,
  output logic                                     writeCycle,
  output logic                                     xferAckStrobe,
  output logic                                     unitDone,
  output logic [dcpa_pkg::NCH-1:0]                 periphClear,
  output logic [dcpa_pkg::NCH-1:0]                 cpuIrqReq,
  output logic [dcpa_pkg::NCH-1:0]                 singleAddr,
  output logic [dcpa_pkg::NCH-1:0]                 cfgError,
  output dcpa_pkg::dcpa_order_type                 prioOrder
);
  import dcpa_pkg::*;

  logic [1:0]     modeIn;
  logic [1:0]     modeReg;
  logic           modeStable;
  dcpa_order_type orderReg;
  dcpa_order_type orderNext;
  dcpa_order_type orderPast;
  dcpa_order_type modeOrder;
  dcpa_order_type shifted;
  dcpa_state_type stReg;
  dcpa_state_type stNext;
  dcpa_state_type firstCyc;
  dcpa_ch_type    chReg;
  dcpa_ch_type    chNext;
  dcpa_ch_type    winCh;
  dcpa_ch_type    doneSlot;
  logic [NCH-1:0] pendReg;
  logic [NCH-1:0] pendNext;
  logic [NCH-1:0] periphPrev;
  logic [NCH-1:0] periphRise;
  logic [NCH-1:0] chanReq;
  logic [NCH-1:0] slotReq;
  logic [NCH-1:0] slotDone;
  logic [NCH-1:0] legal;
  logic [NCH-1:0] single;
  logic [NCH-1:0] extLvl;
  logic [NCH-1:0] chHot;
  logic [NCH-1:0] clrVec;
  logic [NCH-1:0] grantReg;
  logic [NCH-1:0] periphClearReg;
  logic [NCH-1:0] cpuIrqReg;
  logic [NCH-1:0] singleReg;
  logic [NCH-1:0] cfgErrReg;
  logic [1:0]     pinS1;
  logic [1:0]     pinS2;
  logic [1:0]     pinS3;
  logic [1:0]     pinLvl;
  logic           startGrant;
  logic           unitEnd;
  logic           burstGo;
  logic           rotate;
  logic           busNext;
  logic           busReqReg;
  logic           readCycReg;
  logic           writeCycReg;
  logic           xferAckReg;
  logic           unitDoneReg;

  function automatic dcpa_ch_type firstSlot(input logic [NCH-1:0] r);
    firstSlot = LOW_SLOT;
    for (int k = NCH - 1; k >= 0; k--)
      if (r[k]) firstSlot = dcpa_ch_type'(k);
  endfunction

  // Pin filter: a level counts only once two stages agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinS1  <= 2'h0;
      pinS2  <= 2'h0;
      pinS3  <= 2'h0;
      pinLvl <= 2'h0;
    end else begin
      pinS1  <= {~extReqPinChB_n, ~extReqPinChA_n};
      pinS2  <= pinS1;
      pinS3  <= pinS2;
      pinLvl <= (pinS2 & pinS3) | (pinLvl & (pinS2 | pinS3));
    end
  end

  // Only channels 0 and 1 have request pins
  assign extLvl = {{(NCH-2){1'b0}}, pinLvl};
  assign modeIn = {prioModeHi, prioModeLo};
  assign modeStable = modeIn == modeReg;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire srcAck = chCfg[c].srcKind == KIND_ACK;
    wire dstAck = chCfg[c].dstKind == KIND_ACK;
    wire srcExt = chCfg[c].srcKind == KIND_EXTM || chCfg[c].srcKind == KIND_MMDEV;
    wire dstExt = chCfg[c].dstKind == KIND_EXTM || chCfg[c].dstKind == KIND_MMDEV;
    assign single[c] = (srcAck && dstExt) || (dstAck && srcExt); // RL16
    // Single address needs a request pin, so only the pin channels qualify
    assign legal[c] = single[c] ? (c < 2) : !(srcAck || dstAck); // RL16
    assign chanReq[c] = chanEn[c] && legal[c] && (pendReg[c] || extLvl[c]);
    assign slotReq[c] = chanReq[orderReg[c]]; // RL6
    assign slotDone[c] = orderReg[c] == chReg;
    if (c == NCH - 1) begin : g_last
      assign shifted[c] = chReg; // RL9
    end else begin : g_mid
      assign shifted[c] = (c >= doneSlot) ? orderReg[c+1] : orderReg[c]; // RL10
    end
  end

  assign winCh = orderReg[firstSlot(slotReq)]; // RL6
  assign doneSlot = firstSlot(slotDone);
  assign startGrant = stReg == ST_IDLE && |chanReq && modeStable;
  assign chNext = startGrant ? winCh : chReg;
  assign chHot = {{(NCH-1){1'b0}}, 1'b1} << chReg;

  // Reload on a mode change so a stale rotation never leaks across modes
  assign modeOrder = (modeIn == PRIO_FIX0) ? ORDER_FIX0 : // RL7
                     (modeIn == PRIO_FIX1) ? ORDER_FIX1 : // RL8
                     (modeIn == PRIO_RR)   ? ORDER_RR :   // RL11
                                             ORDER_EXT;   // RL13

  assign unitEnd = cycleAck && (stReg == ST_SINGLE || stReg == ST_WRITE);
  // Ext mode keeps channels 2 and 3 out of the rotation
  assign rotate = unitEnd && modeStable && doneSlot != LOW_SLOT && // RL14
                  (modeReg == PRIO_RR || (modeReg == PRIO_EXT && !chReg[1])); // RL12
  assign orderNext = !modeStable ? modeOrder : // RL20
                     rotate      ? shifted : orderReg;

  assign periphRise = periphReq & ~periphPrev;
  assign clrVec = (unitEnd && (!chCfg[chReg].burst || chCfg[chReg].last)) ? // RL4 RL5
                  chHot : {NCH{1'b0}};
  // A new request in the clearing cycle survives
  assign pendNext = periphRise | (pendReg & ~clrVec);

  assign burstGo = chCfg[chReg].burst && !chCfg[chReg].last && chanReq[chReg]; // RL5
  assign firstCyc = single[chNext] ? ST_SINGLE : ST_READ; // RL15
  assign busNext = stNext != ST_IDLE && stNext != ST_RELEASE;

  always_comb begin
    stNext = stReg;
    unique case (stReg)
      ST_IDLE: begin
        if (startGrant) stNext = ST_BUSWAIT;
      end
      ST_BUSWAIT: begin
        if (busGranted) stNext = firstCyc;
      end
      ST_SINGLE, ST_WRITE: begin
        if (cycleAck) stNext = burstGo ? firstCyc : ST_RELEASE; // RL18
      end
      ST_READ: begin
        if (cycleAck) stNext = ST_WRITE; // RL15
      end
      ST_RELEASE: begin
        stNext = ST_IDLE; // RL18
      end
      default: begin
        stNext = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      modeReg   <= PRIO_FIX0;
      orderReg  <= ORDER_FIX0;
      orderPast <= ORDER_FIX0;
      stReg     <= ST_IDLE;
      chReg     <= 2'h0;
    end else begin
      modeReg   <= modeIn;
      orderReg  <= orderNext;
      orderPast <= orderReg;
      stReg     <= stNext;
      chReg     <= chNext;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pendReg    <= 4'h0;
      periphPrev <= 4'h0;
      cpuIrqReg  <= 4'h0;
    end else begin
      pendReg    <= pendNext;
      periphPrev <= periphReq;
      cpuIrqReg  <= periphReq; // RL2
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      grantReg       <= 4'h0;
      busReqReg      <= 1'b0;
      readCycReg     <= 1'b0;
      writeCycReg    <= 1'b0;
      xferAckReg     <= 1'b0;
      unitDoneReg    <= 1'b0;
      periphClearReg <= 4'h0;
      singleReg      <= 4'h0;
      cfgErrReg      <= 4'h0;
    end else begin
      grantReg       <= busNext ? ({{(NCH-1){1'b0}}, 1'b1} << chNext) : {NCH{1'b0}};
      busReqReg      <= busNext;
      readCycReg     <= stNext == ST_READ;
      writeCycReg    <= stNext == ST_WRITE;
      xferAckReg     <= stNext == ST_SINGLE; // RL17
      unitDoneReg    <= unitEnd;
      periphClearReg <= clrVec;
      singleReg      <= single;
      cfgErrReg      <= ~legal;
    end
  end

  assign grant         = grantReg;
  assign busReq        = busReqReg;
  assign readCycle     = readCycReg;
  assign writeCycle    = writeCycReg;
  assign xferAckStrobe = xferAckReg;
  assign unitDone      = unitDoneReg;
  assign periphClear   = periphClearReg;
  assign cpuIrqReq     = cpuIrqReg;
  assign singleAddr    = singleReg;
  assign cfgError      = cfgErrReg;
  assign prioOrder     = orderReg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence sSingleEnd;
    stReg == ST_SINGLE && cycleAck;
  endsequence

  sequence sStealEnd;
    unitEnd && !chCfg[chReg].burst;
  endsequence

  a_fixed_zero_top: assert property ( // RL7
    startGrant && modeReg == PRIO_FIX0 && chanReq[0] |=> grantReg == 4'h1)
    else $error("mode 00 did not grant channel 0");

  a_fixed_one_top: assert property ( // RL8
    startGrant && modeReg == PRIO_FIX1 && chanReq[1] |=> grantReg == 4'h2)
    else $error("mode 01 did not grant channel 1");

  a_rr_to_bottom: assert property ( // RL9
    rotate |=> orderReg[LOW_SLOT] == $past(chReg))
    else $error("finished channel not at bottom");

  a_rr_keep_order: assert property ( // RL10
    rotate && doneSlot == 2'h0 |=> orderReg[2:0] == orderPast[3:1])
    else $error("lower channels did not move up in order");

  a_lowest_hold: assert property ( // RL14
    unitEnd && modeStable && doneSlot == LOW_SLOT |=> orderReg == orderPast)
    else $error("order changed for lowest channel");

  a_ext_fixed_top: assert property ( // RL12
    modeReg == PRIO_EXT && modeStable |-> orderReg[1:0] == ORDER_EXT[1:0])
    else $error("channels 2 and 3 moved in pin round-robin");

  a_mode_reload: assert property ( // RL20
    !modeStable |=> orderReg == $past(modeOrder) && modeStable)
    else $error("mode change did not reload order");

  a_steal_withdraw: assert property ( // RL4
    unitEnd && !chCfg[chReg].burst && !periphRise[chReg]
    |=> (pendReg & $past(chHot)) == 4'h0)
    else $error("cycle-steal request not withdrawn");

  a_burst_hold: assert property ( // RL5
    unitEnd && chCfg[chReg].burst && !chCfg[chReg].last
    |=> ($past(pendReg) & ~pendReg & $past(chHot)) == 4'h0)
    else $error("burst request withdrawn early");

  a_cpu_irq_copy: assert property ( // RL2
    ##1 cpuIrqReg == $past(periphReq))
    else $error("request not forwarded to cpu");

  a_single_one_cycle: assert property ( // RL17
    sSingleEnd |=> unitDoneReg && !readCycReg && !writeCycReg)
    else $error("single address unit not one bus cycle");

  a_steal_release: assert property ( // RL18
    sStealEnd |=> !busReqReg ##1 stReg == ST_IDLE)
    else $error("cycle-steal did not release the bus");

  a_illegal_nogrant: assert property ( // RL16
    startGrant |=> (grantReg & cfgErrReg) == 4'h0)
    else $error("illegal address pairing granted");

  a_grant_onehot: assert property ( // RL6
    $onehot0(grantReg))
    else $error("more than one channel granted");
endmodule

// File: dv/dcpa_arbiter_tb.sv
/*
 Self-checking bench for the DMA priority arbiter: pairing decode, burst,
 pin round-robin and random request rounds in all modes. Assumes the
 far-side model dcpa_far_model.
*/
`timescale 1ns/100ps
module dcpa_arbiter_tb;
  import dcpa_pkg::*;
  logic                   ref_clk = 1'b0;
  logic                   rstn    = 1'b0;
  logic                   modeHi  = 1'b0;
  logic                   modeLo  = 1'b0;
  dcpa_cfg_type [NCH-1:0] chCfg   = '0;
  logic [3:0]             chanEn  = 4'hF;
  logic [3:0]             fire    = 4'h0;
  logic [3:0]             irqEn   = 4'h0;
  logic [1:0]             pinReq  = 2'h0;
  logic                   slow    = 1'b0;
  logic [3:0]             periphReq, grant, periphClear, cpuIrqReq, singleAddr, cfgError, g;
  logic                   pinA_n, pinB_n, busGranted, cycleAck, busReq;
  logic                   cpuTook;
  logic                   readCycle, writeCycle, xferAckStrobe, unitDone;
  dcpa_order_type         prioOrder;
  dcpa_order_type         expOrd  = 8'h6C;
  logic [1:0]             curM    = 2'h0;
  logic [1:0]             nR = 2'h0, nW = 2'h0, nS = 2'h0;
  logic [3:0]             prevReq = 4'h0;
  logic [1:0]             e;
  int                     seed    = 92;
  int                     bad_count = 0;
  int                     n_tests = 0;
  dcpa_order_type         tab [4] = '{8'h6C, 8'h2D, 8'h6C, 8'h1B};

  always #2.5 ref_clk = ~ref_clk;

  dcpa_arbiter dut_u (.ref_clk(ref_clk), .rstn(rstn), .prioModeHi(modeHi),
    .prioModeLo(modeLo), .chCfg(chCfg), .chanEn(chanEn), .periphReq(periphReq),
    .extReqPinChA_n(pinA_n), .extReqPinChB_n(pinB_n), .busGranted(busGranted),
    .cycleAck(cycleAck), .grant(grant), .busReq(busReq), .readCycle(readCycle),
    .writeCycle(writeCycle), .xferAckStrobe(xferAckStrobe), .unitDone(unitDone),
    .periphClear(periphClear), .cpuIrqReq(cpuIrqReq), .singleAddr(singleAddr),
    .cfgError(cfgError), .prioOrder(prioOrder));

  dcpa_far_model far_u (.ref_clk(ref_clk), .rstn(rstn), .fire(fire), .irqEn(irqEn),
    .pinReq(pinReq), .slow(slow), .periphClear(periphClear), .busReq(busReq),
    .busCyc(readCycle | writeCycle | xferAckStrobe), .cpuIrqReq(cpuIrqReq),
    .cpuTook(cpuTook), .periphReq(periphReq),
    .extReqPinChA_n(pinA_n), .extReqPinChB_n(pinB_n), .busGranted(busGranted),
    .cycleAck(cycleAck));

  task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Rotation model: finished channel to bottom, lower ones move up
  function automatic dcpa_order_type nextOrd(dcpa_order_type o, logic [1:0] m, dcpa_ch_type c);
    int k;
    int lo;
    k = 0;
    for (int i = 0; i < NCH; i++) if (o[i] == c) k = i;
    lo = (m == PRIO_EXT) ? 2 : 0;
    if ((m == PRIO_RR || m == PRIO_EXT) && k >= lo && k < 3) begin
      for (int i = k; i < 3; i++) o[i] = o[i+1];
      o[3] = c;
    end
    return o;
  endfunction

  function automatic logic [3:0] win(dcpa_order_type o, logic [3:0] s);
    win = 4'h0;
    for (int i = 3; i >= 0; i--) if (s[o[i]]) win = 4'h1 << o[i];
  endfunction

  // {error, single} for a source and destination kind on channel 0
  function automatic logic [1:0] pairExp(logic [2:0] s, logic [2:0] d);
    logic sg;
    sg = (s == KIND_ACK && (d == KIND_EXTM || d == KIND_MMDEV)) ||
         (d == KIND_ACK && (s == KIND_EXTM || s == KIND_MMDEV));
    return {(s == KIND_ACK || d == KIND_ACK) && !sg, sg};
  endfunction

  always @(posedge ref_clk) begin
    prevReq <= periphReq;
    if (cycleAck) begin
      nR <= nR + 2'(readCycle);
      nW <= nW + 2'(writeCycle);
      nS <= nS + 2'(xferAckStrobe);
    end
  end
  always @(negedge ref_clk) begin
    if (rstn) begin
      chk("cpuIrqReq", {4'h0, prevReq}, {4'h0, cpuIrqReq});
      chk("cpuTook", 8'h00, {7'h0, cpuTook});
    end
  end

  // Bounded wait for a grant (0) or a unit end (1)
  task automatic waitSig(logic sel);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((sel ? unitDone : |grant) !== 1'b1 && n < 80);
    if (n >= 80) begin
      bad_count++;
      test_done();
    end
  endtask

  task automatic unit(logic dual, logic hold);
    waitSig(1'b1);
    chk("cycles", dual ? 8'h14 : 8'h01, {2'h0, nR, nW, nS});
    chk("busReq", {7'h0, hold}, {7'h0, busReq});
    nR = 2'h0;
    nW = 2'h0;
    nS = 2'h0;
  endtask

  task automatic round(logic [1:0] m, logic [3:0] set, logic [3:0] en);
    logic [3:0] left;
    logic [3:0] gg;
    dcpa_ch_type c;
    {modeHi, modeLo} = m;
    if (m != curM) expOrd = tab[m];
    curM = m;
    for (int i = 0; i < NCH; i++)
      chCfg[i] = '{1'b0, 1'b0, 3'(1 + {$random(seed)} % 4), 3'(1 + {$random(seed)} % 4)};
    repeat (3) @(negedge ref_clk);
    chk("prioOrder", expOrd, prioOrder);
    // Far model samples on this edge too, so change after it
    irqEn <= en;
    fire  <= set;
    @(negedge ref_clk);
    fire <= 4'h0;
    left = set & en;
    while (left != 4'h0) begin
      waitSig(1'b0);
      gg = grant;
      chk("grant", {4'h0, win(expOrd, left)}, {4'h0, gg});
      for (int i = 0; i < NCH; i++) if (gg[i]) c = 2'(i);
      unit(1'b1, 1'b0);
      chk("periphClear", {4'h0, gg}, {4'h0, periphClear});
      expOrd = nextOrd(expOrd, m, c);
      chk("prioOrder", expOrd, prioOrder);
      left = left & ~gg;
    end
    repeat (4) @(negedge ref_clk);
    chk("grant idle", 8'h00, {4'h0, grant});
  endtask

  initial begin
    repeat (8) @(negedge ref_clk);
    chk("reset order", 8'h6C, prioOrder);
    rstn = 1'b1;
    for (int s = 0; s < 5; s++) for (int d = 0; d < 5; d++) begin
      chCfg[0] = '{1'b0, 1'b0, 3'(s), 3'(d)};
      chCfg[2] = chCfg[0];
      repeat (2) @(negedge ref_clk);
      e = pairExp(3'(s), 3'(d));
      chk("singleAddr", {7'h0, e[0]}, {7'h0, singleAddr[0]});
      chk("cfgError", {7'h0, e[1]}, {7'h0, cfgError[0]});
      chk("cfgError ch2", {7'h0, |e}, {7'h0, cfgError[2]});
    end
    // Illegal pairing keeps its request pending but never granted
    chCfg[2] = '{1'b0, 1'b0, KIND_ACK, KIND_ONMEM};
    irqEn <= 4'hF;
    fire  <= 4'h4;
    @(negedge ref_clk);
    fire <= 4'h0;
    repeat (6) @(negedge ref_clk);
    chk("illegal grant", 8'h00, {4'h0, grant});
    // Burst from memory source, never a serial port source
    chCfg[2] = '{1'b1, 1'b0, KIND_EXTM, KIND_ONMEM};
    for (int i = 0; i < 3; i++) begin
      if (i == 2) chCfg[2].last = 1'b1;
      unit(1'b1, i < 2);
      chk("periphClear", (i < 2) ? 8'h00 : 8'h04, {4'h0, periphClear});
    end
    round(PRIO_EXT, 4'h0, 4'h0);
    chCfg[0] = '{1'b0, 1'b0, KIND_ACK, KIND_EXTM};
    chCfg[1] = '{1'b0, 1'b0, KIND_EXTM, KIND_ACK};
    slow <= 1'b1;
    pinReq = 2'h3;
    for (int i = 0; i < 3; i++) begin
      waitSig(1'b0);
      g = grant;
      chk("pin grant", {4'h0, win(expOrd, {2'h0, pinReq})}, {4'h0, g});
      pinReq = pinReq & ~g[1:0];
      unit(1'b0, 1'b0);
      expOrd = nextOrd(expOrd, PRIO_EXT, g[1] ? 2'h1 : 2'h0);
      chk("pin order", expOrd, prioOrder);
      if (i == 1) pinReq = 2'h1;
    end
    slow <= 1'b0;
    round(PRIO_RR, 4'hF, 4'hF);
    round(PRIO_FIX1, 4'hF, 4'hF);
    repeat (40) round(2'($random(seed)), 4'($random(seed)), 4'($random(seed)));
    test_done();
  end
endmodule

// File: dv/dcpa_far_model.sv
/*
 Far-side model: peripheral request sources, the two request pins and
 the bus-cycle engine. Assumes its inputs change at the falling edge.
*/
`timescale 1ns/100ps
module dcpa_far_model (
  input  logic       ref_clk,
  input  logic       rstn,
  input  logic [3:0] fire,
  input  logic [3:0] irqEn,
  input  logic [1:0] pinReq,
  input  logic       slow,
  input  logic [3:0] periphClear,
  input  logic       busReq,
  input  logic       busCyc,
  input  logic [3:0] cpuIrqReq,
  output logic       cpuTook,
  output logic [3:0] periphReq = 4'h0,
  output logic       extReqPinChA_n,
  output logic       extReqPinChB_n,
  output logic       busGranted = 1'b0,
  output logic       cycleAck = 1'b0
);
  int gCnt;
  int aCnt;
  // Software keeps the request level at or below the CPU mask
  localparam logic [3:0] IRQ_LEVEL    = 4'h2;
  localparam logic [3:0] CPU_IRQ_MASK = 4'h7;
  assign cpuTook = |cpuIrqReq && IRQ_LEVEL > CPU_IRQ_MASK;
  // Pins are active low level requests
  assign extReqPinChA_n = ~pinReq[0];
  assign extReqPinChB_n = ~pinReq[1];
  always @(negedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      periphReq <= 4'h0;
      busGranted <= 1'b0;
      cycleAck <= 1'b0;
      gCnt <= 0;
      aCnt <= 0;
    end else begin
      // Request only with own enable; held until withdrawn
      periphReq <= (periphReq & ~periphClear) | (fire & irqEn);
      // Slow mode stretches grant and ack so pin releases settle
      gCnt <= busReq ? gCnt + 1 : 0;
      busGranted <= busReq && gCnt >= (slow ? 4 : 0);
      aCnt <= (busCyc && !cycleAck) ? aCnt + 1 : 0;
      cycleAck <= busCyc && !cycleAck && aCnt >= (slow ? 4 : 0);
    end
  end
endmodule

// File: shared/dcpa_pkg.sv
/*
 Codes, reset orders, state encoding and carriers for the DMA channel
 priority arbiter. Assumes one ref_clk domain and one design module.
*/
// Summary of operation
// RL1: A peripheral raises its DMA request only while its own interrupt enable is set.
// RL2: Every peripheral request line also goes to the CPU interrupt path.
// RL3: Software keeps such a peripheral's interrupt level at or below the CPU mask.
// RL4: In cycle-steal mode a pending peripheral request clears after the first transfer.
// RL5: In burst mode a pending peripheral request holds until the final transfer.
// RL6: With several requests pending, one channel wins by the selected priority mode.
// RL7: Mode 00 is fixed order: channel 0, 3, 2, 1.
// RL8: Mode 01 is fixed order: channel 1, 3, 2, 0.
// RL9: Round-robin: the channel that finished a unit drops to the bottom.
// RL10: Channels below the finished one move up one place, order kept.
// RL11: Round-robin starts as channel 0, 3, 2, 1.
// RL12: External-pin round-robin rotates only channels 0 and 1; 2 and 3 stay.
// RL13: External-pin round-robin starts as channel 3, 2, 1, 0.
// RL14: A finished channel already in the lowest rotating place leaves order unchanged.
// RL15: Single and dual address modes, cycle-steal and burst bus modes are supported.
// RL16: An acknowledge device pairs only with external memory or mapped device, single mode.
// RL17: A single address transfer takes one bus cycle with the acknowledge strobe.
// RL18: Cycle-steal releases the bus after each unit and reacquires it later.
// RL19: Software never selects burst mode with a serial port as request source.
// RL20: Codes 10 and 11 select the two round-robins; a mode change reloads order.
package dcpa_pkg;
  localparam int         NCH        = 4;
  localparam logic [1:0] PRIO_FIX0  = 2'h0;
  localparam logic [1:0] PRIO_FIX1  = 2'h1;
  localparam logic [1:0] PRIO_RR    = 2'h2;
  localparam logic [1:0] PRIO_EXT   = 2'h3;
  localparam logic [1:0] LOW_SLOT   = 2'h3;
  localparam logic [2:0] KIND_ACK   = 3'h0;
  localparam logic [2:0] KIND_EXTM  = 3'h1;
  localparam logic [2:0] KIND_MMDEV = 3'h2;
  localparam logic [2:0] KIND_ONMEM = 3'h3;
  localparam logic [2:0] KIND_PERI  = 3'h4;

  typedef logic [1:0] dcpa_ch_type;
  // Slot 0 (low bits) is the highest priority
  typedef dcpa_ch_type [NCH-1:0] dcpa_order_type;

  localparam dcpa_order_type ORDER_FIX0 = 8'h6C;
  localparam dcpa_order_type ORDER_FIX1 = 8'h2D;
  localparam dcpa_order_type ORDER_RR   = 8'h6C;
  localparam dcpa_order_type ORDER_EXT  = 8'h1B;

  typedef struct packed {
    logic       burst;
    logic       last;
    logic [2:0] srcKind;
    logic [2:0] dstKind;
  } dcpa_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_BUSWAIT = 3'h1,
    ST_SINGLE  = 3'h2,
    ST_READ    = 3'h3,
    ST_WRITE   = 3'h4,
    ST_RELEASE = 3'h5
  } dcpa_state_type;
endpackage
